// ==== inc/ccm_pkg.sv ====
package ccm_pkg;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_PS = 4000;
	localparam int WAKE_DELAY_US = 500;
	localparam int WAKE_CYCLES = (WAKE_DELAY_US * 1000000) / CLK_PERIOD_PS;

	// ----------------------------------------
	// Variable map
	// ----------------------------------------
	localparam logic [15:0] HOST_STATE_CLOCK_SELECT_ADDR = 16'h02FD;
	localparam logic [15:0] RF_STATE_CLOCK_SELECT_ADDR = 16'h02FE;
	localparam logic [15:0] IDLE_STATE_CLOCK_SELECT_ADDR = 16'h02FF;
	localparam logic [7:0] HOST_STATE_CLOCK_SELECT_RST = 8'h00;
	localparam logic [7:0] RF_STATE_CLOCK_SELECT_RST = 8'h00;
	localparam logic [7:0] IDLE_STATE_CLOCK_SELECT_RST = 8'h02;
	localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

	// ----------------------------------------
	// Clock codes and divider masks
	// ----------------------------------------
	localparam logic [7:0] FREQ_CODE_FULL = 8'h00;
	localparam logic [7:0] FREQ_CODE_HALF = 8'h01;
	localparam logic [7:0] FREQ_CODE_QUARTER = 8'h02;
	localparam logic [1:0] DIV_MASK_FULL = 2'h0;
	localparam logic [1:0] DIV_MASK_HALF = 2'h1;
	localparam logic [1:0] DIV_MASK_QUARTER = 2'h3;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [2:0] {
		ACT_IDLE = 3'h1,
		ACT_HOST = 3'h2,
		ACT_RF = 3'h4
	} ccm_act_t;

	typedef enum logic [3:0] {
		CPU_HARD_PD = 4'h1,
		CPU_NORMAL = 4'h2,
		CPU_POWER_DOWN = 4'h4,
		CPU_WAKE = 4'h8
	} ccm_cpu_t;

	typedef enum logic [1:0] {
		FE_ACTIVE_FIELD_OFF = 2'h0,
		FE_ACTIVE_FIELD_ON = 2'h1,
		FE_LEVEL_DETECT_ONLY = 2'h2,
		FE_MINIMUM_POWER = 2'h3
	} ccm_fe_mode_t;

	typedef struct packed {
		logic valid;
		logic [15:0] addr;
		logic [7:0] data;
	} ccm_var_wr_t;

	typedef struct packed {
		logic uart_reset;
		logic afe_reset;
		logic uart_run;
		logic afe_on;
		logic field_on;
		logic level_detect_on;
	} ccm_fe_ctrl_t;

endpackage

// ==== hdl/ccm_clock_power_mgr.sv ====
// What this block does
// [R1] With no host or RF traffic the activity state is idle.
// [R2] While only host data moves the activity state is host.
// [R3] While RF data moves the activity state is RF.
// [R4] Each state change switches the CPU clock to that state's code, unaided.
// [R5] Codes 0x00, 0x01, 0x02 select full, half and quarter of the 250 MHz system clock.
// [R6] Host rewrites the three clock codes at run time by variable writes.
// [R7] Hard power-down holds CPU in reset, entered only through the pin.
// [R8] CPU power-down stops the oscillator; waking takes about 500 us.
// [R9] Front-end hard power-down resets UART and analog, only through the pin.
// [R10] Active modes run UART and analog; field off or on.
// [R11] Level-detect mode: UART down, no field, only level detector on.
// [R12] Minimum mode: UART, analog and level detector all down.
// [R13] Host wakes a powered-down device before each new command.
// [R14] After waking, the resumed state's clock applies before traffic runs.
`timescale 1ns/1ps
`default_nettype none

module ccm_clock_power_mgr #(
	parameter int WAKE_CYCLES = ccm_pkg::WAKE_CYCLES
) (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_in,
	// Pins
	input wire logic reset_powerdown_pin_n_in,
	input wire logic host_wake_in,
	// Activity from firmware logic
	input wire logic host_xfer_in,
	input wire logic rf_xfer_in,
	input wire logic cpu_powerdown_req_in,
	input wire ccm_pkg::ccm_fe_mode_t fe_mode_req_in,
	// Host variable access
	input wire ccm_pkg::ccm_var_wr_t var_wr_in,
	input wire logic [15:0] var_rd_addr_in,
	output logic [7:0] var_rd_data_out,
	// Clock and power control
	output logic [7:0] cpu_clock_select_out,
	output logic cpu_clk_en_out,
	output logic cpu_reset_out,
	output logic osc_run_out,
	output logic traffic_allowed_out,
	output ccm_pkg::ccm_act_t activity_out,
	output ccm_pkg::ccm_cpu_t cpu_mode_out,
	output ccm_pkg::ccm_fe_ctrl_t fe_ctrl_out
);

	// ----------------------------------------
	// Functions
	// ----------------------------------------
	function automatic logic [1:0] div_mask(input logic [7:0] code);
		logic [1:0] m;
		m = ccm_pkg::DIV_MASK_QUARTER;
		if (code == ccm_pkg::FREQ_CODE_FULL)
			m = ccm_pkg::DIV_MASK_FULL;
		else if (code == ccm_pkg::FREQ_CODE_HALF)
			m = ccm_pkg::DIV_MASK_HALF;
		return m;
	endfunction

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [1:0] pdn_sync_q;
	logic [1:0] wake_sync_q;
	wire pin_low = !pdn_sync_q[1];
	wire wake_req = wake_sync_q[1];

	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			pdn_sync_q <= 2'h0;
			wake_sync_q <= 2'h0;
		end
		else
		begin
			pdn_sync_q <= {pdn_sync_q[0], reset_powerdown_pin_n_in};
			wake_sync_q <= {wake_sync_q[0], host_wake_in};
		end
	end

	// ----------------------------------------
	// CPU power mode
	// ----------------------------------------
	ccm_pkg::ccm_cpu_t cpu_q, cpu_d;
	logic [31:0] wake_cnt_q;
	wire wake_done = (wake_cnt_q == 32'(WAKE_CYCLES - 1));

	always_comb
	begin
		cpu_d = cpu_q;
		unique case (cpu_q)
			ccm_pkg::CPU_HARD_PD: if (!pin_low) cpu_d = ccm_pkg::CPU_NORMAL; // see [R7]
			ccm_pkg::CPU_NORMAL: if (cpu_powerdown_req_in) cpu_d = ccm_pkg::CPU_POWER_DOWN;
			ccm_pkg::CPU_POWER_DOWN: if (wake_req) cpu_d = ccm_pkg::CPU_WAKE; // see [R13]
			ccm_pkg::CPU_WAKE: if (wake_done) cpu_d = ccm_pkg::CPU_NORMAL; // see [R8]
			default: cpu_d = ccm_pkg::CPU_HARD_PD;
		endcase
		if (pin_low)
			cpu_d = ccm_pkg::CPU_HARD_PD; // see [R7]
	end

	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
			cpu_q <= ccm_pkg::CPU_HARD_PD;
		else
			cpu_q <= cpu_d;
	end

	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
			wake_cnt_q <= 32'h0;
		else if (cpu_q == ccm_pkg::CPU_WAKE && !wake_done)
			wake_cnt_q <= wake_cnt_q + 32'h1; // see [R8]
		else
			wake_cnt_q <= 32'h0;
	end

	wire cpu_running = (cpu_q == ccm_pkg::CPU_NORMAL);
	wire hard_pd = (cpu_q == ccm_pkg::CPU_HARD_PD);

	// ----------------------------------------
	// Clock select variables
	// ----------------------------------------
	logic [7:0] host_sel_q, rf_sel_q, idle_sel_q;
	wire wr_ok = var_wr_in.valid && cpu_running;

	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			host_sel_q <= ccm_pkg::HOST_STATE_CLOCK_SELECT_RST;
			rf_sel_q <= ccm_pkg::RF_STATE_CLOCK_SELECT_RST;
			idle_sel_q <= ccm_pkg::IDLE_STATE_CLOCK_SELECT_RST;
		end
		else if (hard_pd)
		begin
			host_sel_q <= ccm_pkg::HOST_STATE_CLOCK_SELECT_RST;
			rf_sel_q <= ccm_pkg::RF_STATE_CLOCK_SELECT_RST;
			idle_sel_q <= ccm_pkg::IDLE_STATE_CLOCK_SELECT_RST;
		end
		else if (wr_ok)
		begin
			if (var_wr_in.addr == ccm_pkg::HOST_STATE_CLOCK_SELECT_ADDR)
				host_sel_q <= var_wr_in.data; // see [R6]
			if (var_wr_in.addr == ccm_pkg::RF_STATE_CLOCK_SELECT_ADDR)
				rf_sel_q <= var_wr_in.data; // see [R6]
			if (var_wr_in.addr == ccm_pkg::IDLE_STATE_CLOCK_SELECT_ADDR)
				idle_sel_q <= var_wr_in.data; // see [R6]
		end
	end

	wire [7:0] rd_mux =
		(var_rd_addr_in == ccm_pkg::HOST_STATE_CLOCK_SELECT_ADDR) ? host_sel_q :
		(var_rd_addr_in == ccm_pkg::RF_STATE_CLOCK_SELECT_ADDR) ? rf_sel_q :
		(var_rd_addr_in == ccm_pkg::IDLE_STATE_CLOCK_SELECT_ADDR) ? idle_sel_q :
		ccm_pkg::UNMAPPED_READ_VALUE;

	// ----------------------------------------
	// Activity state
	// ----------------------------------------
	ccm_pkg::ccm_act_t act_q;
	// Frozen on the last wake edge so the clock code is settled before traffic
	wire act_update = cpu_running || (cpu_q == ccm_pkg::CPU_WAKE && !wake_done); // see [R14]
	wire ccm_pkg::ccm_act_t act_next =
		rf_xfer_in ? ccm_pkg::ACT_RF : // see [R3]
		host_xfer_in ? ccm_pkg::ACT_HOST : // see [R2]
		ccm_pkg::ACT_IDLE; // see [R1]

	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
			act_q <= ccm_pkg::ACT_IDLE;
		else if (hard_pd)
			act_q <= ccm_pkg::ACT_IDLE;
		else if (act_update)
			act_q <= act_next; // see [R14]
	end

	wire [7:0] sel_now =
		(act_q == ccm_pkg::ACT_RF) ? rf_sel_q :
		(act_q == ccm_pkg::ACT_HOST) ? host_sel_q :
		idle_sel_q; // see [R4]

	// ----------------------------------------
	// Clock divider and outputs
	// ----------------------------------------
	logic [1:0] div_cnt_q;
	logic clk_en_q;
	logic [7:0] sel_q;
	logic [7:0] rd_q;
	ccm_pkg::ccm_fe_ctrl_t fe_q, fe_d;

	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			div_cnt_q <= 2'h0;
			clk_en_q <= 1'b0;
			sel_q <= ccm_pkg::IDLE_STATE_CLOCK_SELECT_RST;
			rd_q <= 8'h00;
		end
		else
		begin
			div_cnt_q <= cpu_running ? div_cnt_q + 2'h1 : 2'h0;
			clk_en_q <= cpu_running && ((div_cnt_q & div_mask(sel_now)) == 2'h0); // see [R5]
			sel_q <= sel_now; // see [R4]
			rd_q <= rd_mux;
		end
	end

	// ----------------------------------------
	// Front-end power mode
	// ----------------------------------------
	always_comb
	begin
		fe_d = '0;
		if (hard_pd)
		begin
			fe_d.uart_reset = 1'b1; // see [R9]
			fe_d.afe_reset = 1'b1; // see [R9]
		end
		else
		begin
			unique case (fe_mode_req_in)
				ccm_pkg::FE_ACTIVE_FIELD_OFF:
				begin
					fe_d.uart_run = 1'b1; // see [R10]
					fe_d.afe_on = 1'b1;
					fe_d.level_detect_on = 1'b1;
				end
				ccm_pkg::FE_ACTIVE_FIELD_ON:
				begin
					fe_d.uart_run = 1'b1; // see [R10]
					fe_d.afe_on = 1'b1;
					fe_d.level_detect_on = 1'b1;
					fe_d.field_on = 1'b1;
				end
				ccm_pkg::FE_LEVEL_DETECT_ONLY: fe_d.level_detect_on = 1'b1; // see [R11]
				ccm_pkg::FE_MINIMUM_POWER: fe_d = '0; // see [R12]
			endcase
		end
	end

	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
			fe_q <= 6'h30;
		else
			fe_q <= fe_d;
	end

	assign var_rd_data_out = rd_q;
	assign cpu_clock_select_out = sel_q;
	assign cpu_clk_en_out = clk_en_q;
	assign cpu_reset_out = hard_pd; // see [R7]
	assign osc_run_out = !(cpu_q == ccm_pkg::CPU_POWER_DOWN); // see [R8]
	assign traffic_allowed_out = cpu_running; // see [R14]
	assign activity_out = act_q;
	assign cpu_mode_out = cpu_q;
	assign fe_ctrl_out = fe_q;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);

	property p_idle_state;
		act_update && !rf_xfer_in && !host_xfer_in |=> act_q == ccm_pkg::ACT_IDLE;
	endproperty
	a_idle_state: assert property (p_idle_state) else $error("idle not entered"); // see [R1]

	property p_host_state;
		act_update && !rf_xfer_in && host_xfer_in |=> act_q == ccm_pkg::ACT_HOST;
	endproperty
	a_host_state: assert property (p_host_state) else $error("host not entered"); // see [R2]

	property p_rf_state;
		act_update && rf_xfer_in |=> act_q == ccm_pkg::ACT_RF;
	endproperty
	a_rf_state: assert property (p_rf_state) else $error("rf not entered"); // see [R3]

	property p_clock_follows;
		$stable(act_q) && $stable({host_sel_q, rf_sel_q, idle_sel_q}) |->
			cpu_clock_select_out == ((act_q == ccm_pkg::ACT_RF) ? rf_sel_q :
			(act_q == ccm_pkg::ACT_HOST) ? host_sel_q : idle_sel_q);
	endproperty
	a_clock_follows: assert property (p_clock_follows) else $error("clock not switched"); // see [R4]

	property p_quarter_rate;
		(cpu_running && sel_now == ccm_pkg::FREQ_CODE_QUARTER) [*4] ##1 cpu_clk_en_out |->
			!$past(cpu_clk_en_out) && !$past(cpu_clk_en_out, 2) && !$past(cpu_clk_en_out, 3);
	endproperty
	a_quarter_rate: assert property (p_quarter_rate) else $error("bad quarter rate"); // see [R5]

	property p_hard_pd_pin;
		$rose(cpu_reset_out) |-> $past(pin_low);
	endproperty
	a_hard_pd_pin: assert property (p_hard_pd_pin) else $error("hard pd without pin"); // see [R7]

	property p_wake_delay;
		$rose(cpu_q == ccm_pkg::CPU_WAKE) |-> !traffic_allowed_out throughout
			(cpu_q == ccm_pkg::CPU_WAKE) [*8];
	endproperty
	a_wake_delay: assert property (p_wake_delay) else $error("cpu ran during wake"); // see [R8]

	property p_fe_reset;
		hard_pd |=> fe_ctrl_out.uart_reset && fe_ctrl_out.afe_reset && !fe_ctrl_out.field_on;
	endproperty
	a_fe_reset: assert property (p_fe_reset) else $error("front end not reset"); // see [R9]

	property p_fe_level;
		!hard_pd && fe_mode_req_in == ccm_pkg::FE_LEVEL_DETECT_ONLY |=>
			!fe_ctrl_out.uart_run && !fe_ctrl_out.field_on && fe_ctrl_out.level_detect_on;
	endproperty
	a_fe_level: assert property (p_fe_level) else $error("level mode wrong"); // see [R11]

	property p_fe_min;
		!hard_pd && fe_mode_req_in == ccm_pkg::FE_MINIMUM_POWER |=> fe_ctrl_out == '0;
	endproperty
	a_fe_min: assert property (p_fe_min) else $error("minimum mode wrong"); // see [R12]

	property p_resume_clock;
		$rose(traffic_allowed_out) |-> cpu_clock_select_out == sel_now;
	endproperty
	a_resume_clock: assert property (p_resume_clock) else $error("stale clock"); // see [R14]

	c_wake: cover property ($fell(cpu_q == ccm_pkg::CPU_WAKE) && cpu_running);
	c_rf: cover property (act_q == ccm_pkg::ACT_RF ##1 act_q == ccm_pkg::ACT_IDLE);
	c_write: cover property (wr_ok && var_wr_in.addr == ccm_pkg::IDLE_STATE_CLOCK_SELECT_ADDR);

endmodule

`default_nettype wire

// ==== dv/ccm_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module ccm_host_model (
	// Clock
	input wire logic clk_in,
	// Device side
	output var ccm_pkg::ccm_var_wr_t var_wr_out,
	output var logic host_wake_out
);
	initial
	begin
		var_wr_out = '0;
		host_wake_out = 1'b0;
	end

	// ----------------------------------------
	// Variable write, one-cycle strobe
	// ----------------------------------------
	task automatic write_var(input logic [15:0] addr, input logic [7:0] data);
		@(posedge clk_in);
		var_wr_out <= '{valid: 1'b1, addr: addr, data: data};
		@(posedge clk_in);
		var_wr_out <= '{valid: 1'b0, addr: ~addr, data: ~data};
	endtask

	// ----------------------------------------
	// Wake, held past the synchroniser
	// ----------------------------------------
	task automatic wake();
		@(posedge clk_in);
		host_wake_out <= 1'b1;
		repeat (4) @(posedge clk_in);
		host_wake_out <= 1'b0;
	endtask
endmodule

`default_nettype wire

// ==== dv/ccm_clock_power_mgr_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none

module ccm_clock_power_mgr_tb_top;
	localparam int WAKE_N = 20;
	logic clk_sys_in = 1'b0;
	logic rst_in = 1'b1;
	logic pin_n = 1'b1;
	logic host_xfer = 1'b0;
	logic rf_xfer = 1'b0;
	logic pd_req = 1'b0;
	ccm_pkg::ccm_fe_mode_t fe_mode = ccm_pkg::FE_ACTIVE_FIELD_OFF;
	logic [15:0] rd_addr = 16'h0000;
	ccm_pkg::ccm_var_wr_t var_wr;
	logic wake;
	logic [7:0] rd_data;
	logic [7:0] clk_sel;
	logic clk_en;
	logic cpu_rst;
	logic osc_run;
	logic traffic;
	ccm_pkg::ccm_act_t act;
	ccm_pkg::ccm_cpu_t cpu_mode;
	ccm_pkg::ccm_fe_ctrl_t fe;
	int fails = 0;
	int checks_done = 0;
	int cycles = 0;

	always #2 clk_sys_in = ~clk_sys_in;

	ccm_host_model host (.clk_in(clk_sys_in), .var_wr_out(var_wr), .host_wake_out(wake));

	ccm_clock_power_mgr #(.WAKE_CYCLES(WAKE_N)) uut (
		.clk_sys_in(clk_sys_in), .rst_in(rst_in), .reset_powerdown_pin_n_in(pin_n),
		.host_wake_in(wake), .host_xfer_in(host_xfer), .rf_xfer_in(rf_xfer),
		.cpu_powerdown_req_in(pd_req), .fe_mode_req_in(fe_mode), .var_wr_in(var_wr),
		.var_rd_addr_in(rd_addr), .var_rd_data_out(rd_data), .cpu_clock_select_out(clk_sel),
		.cpu_clk_en_out(clk_en), .cpu_reset_out(cpu_rst), .osc_run_out(osc_run),
		.traffic_allowed_out(traffic), .activity_out(act), .cpu_mode_out(cpu_mode),
		.fe_ctrl_out(fe)
	);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic report_and_stop();
		$display("checks %0d errors %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks_done++;
		if (got !== exp)
		begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys_in);
		#1;
	endtask

	task automatic rd(input logic [15:0] addr, input logic [7:0] exp);
		@(posedge clk_sys_in);
		rd_addr <= addr;
		cyc(2);
		chk("read data", exp, rd_data);
	endtask

	task automatic en_count(input int exp);
		int n;
		n = 0;
		repeat (8)
		begin
			cyc(1);
			if (clk_en === 1'b1)
				n++;
		end
		chk("clock enables in 8", exp[7:0], n[7:0]);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		rd(ccm_pkg::HOST_STATE_CLOCK_SELECT_ADDR, 8'h00);
		rd(ccm_pkg::RF_STATE_CLOCK_SELECT_ADDR, 8'h00);
		rd(ccm_pkg::IDLE_STATE_CLOCK_SELECT_ADDR, 8'h02);
		rd(16'h02FC, ccm_pkg::UNMAPPED_READ_VALUE);
		chk("activity", {5'h00, ccm_pkg::ACT_IDLE}, {5'h00, act});
		chk("clock select", 8'h02, clk_sel);
		en_count(2);
	endtask

	task automatic t_activity();
		host.write_var(ccm_pkg::HOST_STATE_CLOCK_SELECT_ADDR, 8'h01);
		host.write_var(ccm_pkg::RF_STATE_CLOCK_SELECT_ADDR, 8'h02);
		@(posedge clk_sys_in);
		host_xfer <= 1'b1;
		cyc(4);
		chk("activity", {5'h00, ccm_pkg::ACT_HOST}, {5'h00, act});
		chk("clock select", 8'h01, clk_sel);
		en_count(4);
		@(posedge clk_sys_in);
		rf_xfer <= 1'b1;
		cyc(4);
		chk("activity", {5'h00, ccm_pkg::ACT_RF}, {5'h00, act});
		chk("clock select", 8'h02, clk_sel);
		@(posedge clk_sys_in);
		rf_xfer <= 1'b0;
		host_xfer <= 1'b0;
		cyc(4);
		chk("activity", {5'h00, ccm_pkg::ACT_IDLE}, {5'h00, act});
	endtask

	task automatic t_codes();
		for (int c = 0; c < 4; c++)
		begin
			host.write_var(ccm_pkg::IDLE_STATE_CLOCK_SELECT_ADDR, c[7:0]);
			cyc(3);
			chk("clock select", c[7:0], clk_sel);
			en_count(c == 0 ? 8 : (c == 1 ? 4 : 2));
		end
	endtask

	task automatic t_power();
		int n;
		@(posedge clk_sys_in);
		pd_req <= 1'b1;
		@(posedge clk_sys_in);
		pd_req <= 1'b0;
		cyc(3);
		chk("osc run", 8'h00, {7'h00, osc_run});
		chk("traffic", 8'h00, {7'h00, traffic});
		chk("cpu mode", {4'h0, ccm_pkg::CPU_POWER_DOWN}, {4'h0, cpu_mode});
		fork
			host.wake();
		join_none
		n = 0;
		while (traffic !== 1'b1 && n < 200)
		begin
			cyc(1);
			n++;
		end
		chk("wake delay in range", 8'h01, {7'h00, n >= WAKE_N && n <= WAKE_N + 8});
		chk("osc run", 8'h01, {7'h00, osc_run});
		chk("clock select", 8'h03, clk_sel);
	endtask

	task automatic t_pin();
		@(posedge clk_sys_in);
		pin_n <= 1'b0;
		cyc(5);
		host.write_var(ccm_pkg::IDLE_STATE_CLOCK_SELECT_ADDR, 8'h01);
		cyc(2);
		chk("cpu reset", 8'h01, {7'h00, cpu_rst});
		chk("cpu mode", {4'h0, ccm_pkg::CPU_HARD_PD}, {4'h0, cpu_mode});
		chk("front end resets", 8'h03, {6'h00, fe.uart_reset, fe.afe_reset});
		@(posedge clk_sys_in);
		pin_n <= 1'b1;
		cyc(6);
		chk("cpu reset", 8'h00, {7'h00, cpu_rst});
		rd(ccm_pkg::IDLE_STATE_CLOCK_SELECT_ADDR, 8'h02);
		rd(ccm_pkg::HOST_STATE_CLOCK_SELECT_ADDR, 8'h00);
	endtask

	task automatic t_fe();
		logic [4:0] exp [4] = '{5'h05, 5'h07, 5'h01, 5'h00};
		logic [7:0] got;
		for (int m = 0; m < 4; m++)
		begin
			@(posedge clk_sys_in);
			fe_mode <= ccm_pkg::ccm_fe_mode_t'(m[1:0]);
			cyc(3);
			got = {3'h0, fe.uart_reset, fe.afe_reset, fe.uart_run, fe.field_on, fe.level_detect_on};
			chk("front end", {3'h0, exp[m]}, got);
			if (m < 2)
				chk("analog on", 8'h01, {7'h00, fe.afe_on});
			if (m == 3)
				chk("analog on", 8'h00, {7'h00, fe.afe_on});
		end
	endtask

	// ----------------------------------------
	// Run
	// ----------------------------------------
	always @(posedge clk_sys_in)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			fails++;
			report_and_stop();
		end
	end

	initial
	begin
		repeat (20) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		cyc(6);
		t_reset();
		t_activity();
		t_codes();
		t_power();
		t_fe();
		t_pin();
		report_and_stop();
	end
endmodule

`default_nettype wire
